// file: rtl/drive_cmd_pkg.sv
package drive_cmd_pkg;

  // Control word bit positions
  localparam int BIT_ON         = 0;
  localparam int BIT_NO_COAST   = 1;
  localparam int BIT_NO_QSTOP   = 2;
  localparam int BIT_ENABLE_OP  = 3;
  localparam int BIT_B4         = 4;  // Ramp enable / task accept
  localparam int BIT_B5         = 5;  // Ramp unfreeze / no intermediate stop
  localparam int BIT_B6         = 6;  // Setpoint enable / activate task
  localparam int BIT_FAULT_ACK  = 7;
  localparam int BIT_JOG_POS    = 8;
  localparam int BIT_JOG_NEG    = 9;
  localparam int BIT_REMOTE     = 10;
  localparam int BIT_HOMING     = 11;
  localparam int BIT_RELATIVE   = 12;
  localparam int BIT_REPLACE    = 13;

  localparam logic [15:0] CMD_WORD_RESET = 16'h0000;
  localparam logic [15:0] SPEED_ZERO     = 16'h0000;

  // Position set number that takes its options from the control word
  localparam logic [7:0] FIELDBUS_SET = 8'h00;

  // Decoded state command
  typedef enum logic [6:0] {
    CMD_NONE        = 7'b0000001,
    CMD_SHUTDOWN    = 7'b0000010,
    CMD_SWITCH_ON   = 7'b0000100,
    CMD_COAST_STOP  = 7'b0001000,
    CMD_QUICK_STOP  = 7'b0010000,
    CMD_DISABLE_OP  = 7'b0100000,
    CMD_ENABLE_OP   = 7'b1000000
  } state_cmd_type;

  // Speed profile selected for the setpoint generator
  typedef enum logic [3:0] {
    PROF_RAMP      = 4'b0001,
    PROF_STEP      = 4'b0010,
    PROF_HOLD      = 4'b0100,
    PROF_EMERGENCY = 4'b1000
  } profile_type;

endpackage

// file: rtl/drive_control_word_decoder.sv
`timescale 1ns/100ps
`default_nettype none

module drive_control_word_decoder (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          telegram_valid,
  input  wire logic [15:0]                   telegram_word,
  input  wire logic [15:0]                   telegram_speed,
  input  wire logic                          positioning_mode,
  input  wire logic                          operation_enabled,
  input  wire logic                          homing_done,
  input  wire logic [7:0]                    selected_set,
  input  wire logic                          set_option_relative,
  input  wire logic                          set_option_replace,
  output logic      [15:0]                   drive_command_word,
  output logic      [15:0]                   speed_target,
  output logic      [15:0]                   speed_setpoint,
  output drive_cmd_pkg::profile_type         speed_profile,
  output drive_cmd_pkg::state_cmd_type       state_command,
  output logic                               state_command_valid,
  output logic                               remote_active,
  output logic                               fault_ack,
  output logic                               pos_start,
  output logic      [7:0]                    pos_set,
  output logic                               pos_relative,
  output logic                               pos_replace,
  output logic                               pos_cancel,
  output logic                               pos_halt,
  output logic                               pos_resume,
  output logic                               jog_pos_start,
  output logic                               jog_pos_stop,
  output logic                               jog_neg_start,
  output logic                               jog_neg_stop,
  output logic                               homing_start,
  output logic                               homing_abort,
  output logic                               homing_active
);
  import drive_cmd_pkg::*;

  logic [15:0] prev_word;
  logic        eval;
  logic [15:0] rise;
  logic [15:0] fall;
  logic        start_ok;
  logic        pos_go;
  // Telegram qualifiers shared by several paths
  logic        speed_eval;
  logic        pos_eval;
  logic        fieldbus_set_sel;
  logic        homing_go;
  logic        homing_stop;
  // Next values of registered outputs
  logic [15:0] next_speed_setpoint;
  profile_type next_speed_profile;
  logic        next_pos_relative;
  logic        next_pos_replace;
  logic        next_pos_cancel;
  logic        next_pos_halt;
  logic        next_pos_resume;
  logic        next_jog_pos_start;
  logic        next_jog_pos_stop;
  logic        next_jog_neg_start;
  logic        next_jog_neg_stop;
  logic        next_homing_active;
  // Decoded command of the present telegram
  state_cmd_type next_state_command;

  // Decode the low nibble into a state command
  function automatic state_cmd_type decode_cmd(input logic [3:0] c);
    if (!c[BIT_NO_COAST]) begin
      decode_cmd = CMD_COAST_STOP;
    end else if (!c[BIT_NO_QSTOP]) begin
      decode_cmd = CMD_QUICK_STOP;
    end else if (!c[BIT_ON]) begin
      decode_cmd = CMD_SHUTDOWN;
    end else if (c[BIT_ENABLE_OP]) begin
      decode_cmd = CMD_ENABLE_OP;
    end else begin
      decode_cmd = CMD_DISABLE_OP;
    end
  endfunction

  // Option of a started run: the word's bit or the set's stored option
  function automatic logic pick_option(input logic from_word, input logic word_bit,
                                       input logic stored_bit);
    if (from_word) begin
      pick_option = word_bit;
    end else begin
      pick_option = stored_bit;
    end
  endfunction

  // One bit of an edge vector, only for a qualified telegram
  function automatic logic edge_hit(input logic qualify, input logic [15:0] edges,
                                    input int pos);
    edge_hit = qualify && edges[pos];
  endfunction

  // Evaluate only telegrams that carry remote control
  // An ignored word still updates the raw copies but never the edge reference
  assign eval = telegram_valid && telegram_word[BIT_REMOTE];

  // Edges between this telegram and the last evaluated one
  // The reference starts at zero, so bits set in the first word count as rises
  assign rise = telegram_word & ~prev_word;
  assign fall = ~telegram_word & prev_word;

  // Start conditions for any positioning run
  // A refused start leaves no pulse behind
  assign start_ok = telegram_word[BIT_B4] && telegram_word[BIT_B5]
                    && !homing_active;
  assign pos_go = eval && positioning_mode && rise[BIT_B6] && start_ok;

  // Last received word, whether evaluated or not
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive_command_word <= CMD_WORD_RESET;
    end else if (telegram_valid) begin
      drive_command_word <= telegram_word;
    end
  end

  // Edge reference: only evaluated telegrams move it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_word <= CMD_WORD_RESET;
    end else if (eval) begin
      prev_word <= telegram_word;
    end
  end

  // Remote flag mirrors bit 10 of each telegram
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      remote_active <= 1'b0;
    end else if (telegram_valid) begin
      remote_active <= telegram_word[BIT_REMOTE];
    end
  end

  // Speed target from telegram data, taken in the same cycle as the word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      speed_target <= SPEED_ZERO;
    end else if (telegram_valid) begin
      speed_target <= telegram_speed;
    end
  end

  // Decoded command of the present telegram
  assign next_state_command = decode_cmd(telegram_word[3:0]);

  // State command, one pulse per evaluated telegram
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_command       <= CMD_NONE;
      state_command_valid <= 1'b0;
    end else begin
      state_command_valid <= eval;
      if (eval) begin
        state_command <= next_state_command;
      end
    end
  end

  // Fault acknowledge on rising edge only
  // A held bit gives one pulse, not one per telegram
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_ack <= 1'b0;
    end else begin
      fault_ack <= edge_hit(eval, rise, BIT_FAULT_ACK);
    end
  end

  // Qualifiers shared by the speed and positioning paths
  // Both modes share one evaluation gate, so bit 10 rules them alike
  assign speed_eval       = eval && !positioning_mode;
  assign pos_eval         = eval && positioning_mode;
  assign fieldbus_set_sel = (selected_set == FIELDBUS_SET);
  assign homing_go        = edge_hit(pos_eval, rise, BIT_HOMING);
  assign homing_stop      = edge_hit(pos_eval, fall, BIT_HOMING);

  // Speed mode setpoint and profile; the order of tests is the priority
  // Bit 6 outranks the freeze so a frozen ramp never blocks a bit 6 zeroing
  always_comb begin
    next_speed_setpoint = speed_setpoint;
    next_speed_profile  = speed_profile;
    if (!operation_enabled) begin
      next_speed_setpoint = SPEED_ZERO;
      next_speed_profile  = PROF_EMERGENCY;
    end else if (!telegram_word[BIT_B6]) begin
      next_speed_setpoint = SPEED_ZERO;
      next_speed_profile  = PROF_STEP;
    end else if (rise[BIT_B6]) begin
      next_speed_setpoint = telegram_speed;
      next_speed_profile  = PROF_STEP;
    end else if (!telegram_word[BIT_B5]) begin
      next_speed_profile  = PROF_HOLD;
    end else if (!telegram_word[BIT_B4]) begin
      next_speed_setpoint = SPEED_ZERO;
      next_speed_profile  = PROF_RAMP;
    end else begin
      next_speed_setpoint = telegram_speed;
      next_speed_profile  = PROF_RAMP;
    end
  end

  // Speed registers load only from evaluated speed mode telegrams
  // Positioning telegrams leave the speed registers untouched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      speed_setpoint <= SPEED_ZERO;
      speed_profile  <= PROF_EMERGENCY;
    end else if (speed_eval) begin
      speed_setpoint <= next_speed_setpoint;
      speed_profile  <= next_speed_profile;
    end
  end

  // Options of a started run: word bits for the fieldbus set, else stored
  // Options are latched only with a start, so later words cannot alter them
  assign next_pos_relative = pick_option(fieldbus_set_sel, telegram_word[BIT_RELATIVE],
                                         set_option_relative);
  assign next_pos_replace  = pick_option(fieldbus_set_sel, telegram_word[BIT_REPLACE],
                                         set_option_replace);

  // Positioning start with set and options
  // Set and options hold until the next accepted start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pos_start    <= 1'b0;
      pos_set      <= FIELDBUS_SET;
      pos_relative <= 1'b0;
      pos_replace  <= 1'b0;
    end else begin
      pos_start <= pos_go;
      if (pos_go) begin
        pos_set      <= selected_set;
        pos_relative <= next_pos_relative;
        pos_replace  <= next_pos_replace;
      end
    end
  end

  // Next values of the cancel and intermediate stop pulses
  // Cancel is a level test, so a held bit 4 of zero keeps blocking
  always_comb begin
    next_pos_cancel = pos_eval && !telegram_word[BIT_B4];
    next_pos_halt   = edge_hit(pos_eval, fall, BIT_B5);
    next_pos_resume = edge_hit(pos_eval, rise, BIT_B5);
  end

  // Cancel and intermediate stop handling
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pos_cancel <= 1'b0;
      pos_halt   <= 1'b0;
      pos_resume <= 1'b0;
    end else begin
      pos_cancel <= next_pos_cancel;
      pos_halt   <= next_pos_halt;
      pos_resume <= next_pos_resume;
    end
  end

  // Next values of the jog pulses
  // Steady jog bits give no pulse; only edges move the axis
  always_comb begin
    next_jog_pos_start = edge_hit(pos_eval, rise, BIT_JOG_POS);
    next_jog_pos_stop  = edge_hit(pos_eval, fall, BIT_JOG_POS);
    next_jog_neg_start = edge_hit(pos_eval, rise, BIT_JOG_NEG);
    next_jog_neg_stop  = edge_hit(pos_eval, fall, BIT_JOG_NEG);
  end

  // Jog starts and stops on edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      jog_pos_start <= 1'b0;
      jog_pos_stop  <= 1'b0;
      jog_neg_start <= 1'b0;
      jog_neg_stop  <= 1'b0;
    end else begin
      jog_pos_start <= next_jog_pos_start;
      jog_pos_stop  <= next_jog_pos_stop;
      jog_neg_start <= next_jog_neg_start;
      jog_neg_stop  <= next_jog_neg_stop;
    end
  end

  // Homing activity: a start sets it, a finish or a stop clears it
  // A start in the same cycle as a finish wins, so homing stays active
  always_comb begin
    next_homing_active = homing_active;
    if (homing_go) begin
      next_homing_active = 1'b1;
    end else if (homing_done || homing_stop) begin
      next_homing_active = 1'b0;
    end
  end

  // Homing start, abort and activity tracking
  // An abort needs an active homing; a late falling edge is ignored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      homing_start  <= 1'b0;
      homing_abort  <= 1'b0;
      homing_active <= 1'b0;
    end else begin
      homing_start  <= homing_go;
      homing_abort  <= homing_stop && homing_active;
      homing_active <= next_homing_active;
    end
  end

endmodule // drive_control_word_decoder

`default_nettype wire

// file: bench/drive_control_word_decoder_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module drive_control_word_checker (
  input wire logic                         clk,
  input wire logic                         sys_rst,
  input wire logic                         telegram_valid,
  input wire logic [15:0]                  telegram_word,
  input wire logic                         positioning_mode,
  input wire drive_cmd_pkg::state_cmd_type state_command,
  input wire logic                         state_command_valid,
  input wire logic                         pos_start,
  input wire logic                         pos_cancel,
  input wire logic                         fault_ack
);
  import drive_cmd_pkg::*;
  logic taken;
  // Telegram accepted under remote control
  assign taken = telegram_valid && telegram_word[BIT_REMOTE];
  // One clock, quiet in reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  AST_EVAL: assert property (taken |=> state_command_valid)
    else $error("No command strobe");
  AST_IGNORE: assert property (telegram_valid && !telegram_word[BIT_REMOTE]
    |=> !state_command_valid && !pos_start && !fault_ack) else $error("Ignored word acted");
  AST_SHUTDOWN: assert property (taken && telegram_word[2:0] == 3'h6
    |=> state_command == CMD_SHUTDOWN) else $error("Shutdown missed");
  AST_COAST: assert property (taken && !telegram_word[BIT_NO_COAST]
    |=> state_command == CMD_COAST_STOP) else $error("Coast stop missed");
  AST_ENABLE: assert property (taken && telegram_word[3:0] == 4'hF
    |=> state_command == CMD_ENABLE_OP) else $error("Enable missed");
  AST_CANCEL: assert property (taken && positioning_mode && !telegram_word[BIT_B4]
    |=> pos_cancel && !pos_start) else $error("Cancel missed");
  AST_START: assert property (pos_start |-> $past(taken && positioning_mode
    && telegram_word[BIT_B4] && telegram_word[BIT_B5])) else $error("Start not allowed");
  AST_FAULT: assert property (fault_ack |->
    $past(taken) && $past(telegram_word[BIT_FAULT_ACK])) else $error("Stray fault ack");
endmodule // drive_control_word_checker
// Attach to the decoder
bind drive_control_word_decoder drive_control_word_checker i_chk (.clk, .sys_rst,
  .telegram_valid, .telegram_word, .positioning_mode, .state_command, .state_command_valid,
  .pos_start, .pos_cancel, .fault_ack);
`default_nettype wire

// file: bench/plc_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module plc_master_model (
  input  wire logic   clk,
  output logic        telegram_valid,
  output logic [15:0] telegram_word,
  output logic [15:0] telegram_speed
);
  // Bus idle until the first telegram
  initial begin
    telegram_valid = 1'b0;
    telegram_word = 16'h0000;
    telegram_speed = 16'h0000;
  end
  // One telegram; the caller reads the outcome back before the next one
  task automatic send(input logic [15:0] w, input logic [15:0] s);
    @(posedge clk);
    #1 telegram_valid = 1'b1;
    telegram_word = w;
    telegram_speed = s;
    @(posedge clk);
    #1 telegram_valid = 1'b0;
    telegram_word = ~w;
    telegram_speed = ~s;
  endtask
endmodule // plc_master_model
`default_nettype wire

// file: bench/tb_drive_control_word_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module tb_drive_control_word_decoder;
  import drive_cmd_pkg::*;
  logic          clk, telegram_valid, state_command_valid, remote_active, fault_ack, pos_start;
  logic          pos_relative, pos_replace, pos_cancel, pos_halt, pos_resume, jog_pos_start;
  logic          jog_pos_stop, jog_neg_start, jog_neg_stop, homing_start, homing_abort;
  logic          homing_active, sys_rst = 1'b1, positioning_mode = 1'b0, homing_done = 1'b0;
  logic          operation_enabled = 1'b1, set_option_relative = 1'b0, set_option_replace = 1'b1;
  logic [7:0]    selected_set = FIELDBUS_SET, pos_set;
  logic [15:0]   telegram_word, telegram_speed, drive_command_word, speed_target, speed_setpoint;
  logic [15:0]   cmds[3] = '{16'h0406, 16'h0405, 16'h0403};
  logic [27:0]   walk[15] = '{28'h0420401, 28'h0460401, 28'h0450201, 28'h0470101, 28'h0570081,
    28'h0670061, 28'h0470011, 28'h0C70009, 28'h0470005, 28'h0C30009, 28'h0C70001, 28'h0470001,
    28'h04F0003, 28'h04F0001, 28'h0070000};
  profile_type   speed_profile;
  state_cmd_type state_command;
  state_cmd_type cmd_exp[3] = '{CMD_SHUTDOWN, CMD_COAST_STOP, CMD_QUICK_STOP};
  int            bad_count = 0, tests_run = 0;
  // Decoder and fieldbus master
  drive_control_word_decoder i_dut (.clk, .sys_rst, .telegram_valid, .telegram_word,
    .telegram_speed, .positioning_mode, .operation_enabled, .homing_done, .selected_set,
    .set_option_relative, .set_option_replace, .drive_command_word, .speed_target,
    .speed_setpoint, .speed_profile, .state_command, .state_command_valid, .remote_active,
    .fault_ack, .pos_start, .pos_set, .pos_relative, .pos_replace, .pos_cancel, .pos_halt,
    .pos_resume, .jog_pos_start, .jog_pos_stop, .jog_neg_start, .jog_neg_stop, .homing_start,
    .homing_abort, .homing_active);
  plc_master_model i_plc (.clk, .telegram_valid, .telegram_word, .telegram_speed);
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Telegram, then its pulses
  task automatic step(input logic [15:0] w, input logic [11:0] e);
    i_plc.send(w, 16'h00C8);
    chk("pulses", {4'h0, e}, {4'h0, pos_start, pos_cancel, pos_halt, pos_resume, jog_pos_start,
      jog_pos_stop, jog_neg_start, jog_neg_stop, homing_start, homing_abort, fault_ack,
      state_command_valid});
  endtask
  // Speed telegram, then setpoint and profile where known
  task automatic spd(input logic [15:0] w, s, set, input logic [3:0] p);
    i_plc.send(w, s);
    if (set !== 16'hFFFF) chk("setpoint", set, speed_setpoint);
    if (p !== 4'h0) chk("profile", {12'h000, p}, {12'h000, speed_profile});
  endtask
  // Counts and verdict
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog, far beyond the run of about 70 cycles
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    end_of_test;
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk("command", {9'h000, CMD_NONE}, {9'h000, state_command});
    step(16'h0040, 12'h000);
    foreach (cmds[i]) begin
      i_plc.send(cmds[i], 16'h0000);
      chk("command", {9'h000, cmd_exp[i]}, {9'h000, state_command});
    end
    spd(16'h047F, 16'h00C8, 16'h00C8, PROF_STEP);
    spd(16'h043F, 16'h00C8, SPEED_ZERO, 4'h0);
    spd(16'h045F, 16'h00C8, 16'h00C8, PROF_STEP);
    spd(16'h044F, 16'h012C, 16'h00C8, PROF_HOLD);
    spd(16'h046F, 16'h012C, 16'hFFFF, PROF_RAMP);
    operation_enabled = 1'b0;
    spd(16'h047F, 16'h012C, 16'hFFFF, PROF_EMERGENCY);
    operation_enabled = 1'b1;
    spd(16'h047F, 16'h012C, 16'hFFFF, PROF_RAMP);
    positioning_mode = 1'b1;
    step(16'h0430, 12'h001);
    step(16'h3470, 12'h801);
    chk("options", 16'h0003, {6'h00, pos_set, pos_relative, pos_replace});
    selected_set = 8'h05;
    step(16'h0430, 12'h001);
    step(16'h1470, 12'h801);
    chk("options", 16'h0015, {6'h00, pos_set, pos_relative, pos_replace});
    foreach (walk[i]) begin
      if (i == 11) begin
        chk("homing", 16'h0001, {15'h0000, homing_active});
        homing_done = 1'b1;
        @(posedge clk);
        #1 homing_done = 1'b0;
      end
      step(walk[i][27:12], walk[i][11:0]);
    end
    chk("word", 16'h0070, drive_command_word);
    chk("target", 16'h00C8, speed_target);
    chk("remote", 16'h0000, {15'h0000, remote_active});
    end_of_test;
  end
endmodule // tb_drive_control_word_decoder
`default_nettype wire
